// file: sarcv_ctrl.v
// Conversion sequencer and control gating of the converter
//
// Summary of operation
// - Conversion starts only when read, chip select and byte select are low.
// - Byte select high blocks conversion starts.
// - Read and byte select are seen only while chip select is low.
// - Data drivers enabled whenever read and chip select are low.
// - Busy output low throughout conversion, high otherwise.
// - Byte select low gives all twelve result bits, MSB on top pin.
// - Byte select high: top pins bits 11-8, middle low, bottom 11-8.
// - Conversion start clears approximation register and enables drivers.
// - Start requests ignored until the running conversion finishes.
// - Result resolved one bit at a time from MSB down to LSB.
// - MSB decided after second falling clock-in edge, then one per edge.
// - Sampling phase holds until start, then compare phase.
// - Finished register value loaded into the twelve-bit output latch.
// - Clock output is the inverse of clock input.
// - A starting read returns the previous conversion result.
`timescale 1ns/10ps
`include "sarcv_defines.vh"
module sarcv_ctrl (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire rd_n,
  input wire high_byte_select,
  input wire clk_in,
  input wire comp_out,
  output wire clk_out,
  output reg busy_n,
  output reg compare_phase,
  output reg [11:0] approximation_register,
  output wire [7:0] upper_data_pins,
  output wire [3:0] shared_low_data_pins,
  output wire data_oe
);
  localparam ST_SAMPLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_CONV = 2'b10;

  reg cs_n_meta_reg;
  reg cs_n_sync_reg;
  reg rd_n_meta_reg;
  reg rd_n_sync_reg;
  reg hb_meta_reg;
  reg hb_sync_reg;
  reg ck_meta_reg;
  reg ck_sync_reg;
  reg ck_last_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] cnt_reg;
  reg [4:0] cnt_next;
  reg busy_n_reg;
  reg busy_n_next;
  reg phase_reg;
  reg phase_next;
  reg [11:0] sar_reg;
  reg [11:0] sar_next;
  reg [11:0] result_reg;
  reg [11:0] result_next;
  wire start_req;
  wire ck_fall;
  wire msb_due;
  wire last_bit;
  wire [3:0] bit_idx;
  wire [11:0] decided_word;

  // Next count of clock-in falls
  function [4:0] count_up;
    input [4:0] count;
    begin
      count_up = count + 5'h01;
    end
  endfunction

  // Register bit decided at a given count
  function [3:0] bit_of;
    input [4:0] count;
    begin
      bit_of = `SARCV_TOP_BIT - count[3:0];
    end
  endfunction

  // Word with one bit replaced by a decision
  function [11:0] set_bit;
    input [11:0] word;
    input [3:0] idx;
    input decision;
    begin
      set_bit = word;
      set_bit[idx] = decision;
    end
  endfunction

  // Chip select synchroniser
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_meta_reg <= `SARCV_PIN_IDLE;
      cs_n_sync_reg <= `SARCV_PIN_IDLE;
    end else begin
      cs_n_meta_reg <= cs_n;
      cs_n_sync_reg <= cs_n_meta_reg;
    end
  end

  // Read strobe synchroniser
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_n_meta_reg <= `SARCV_PIN_IDLE;
      rd_n_sync_reg <= `SARCV_PIN_IDLE;
    end else begin
      rd_n_meta_reg <= rd_n;
      rd_n_sync_reg <= rd_n_meta_reg;
    end
  end

  // Byte select synchroniser, idles in the blocking level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hb_meta_reg <= `SARCV_PIN_IDLE;
      hb_sync_reg <= `SARCV_PIN_IDLE;
    end else begin
      hb_meta_reg <= high_byte_select;
      hb_sync_reg <= hb_meta_reg;
    end
  end

  // Clock-in synchroniser and edge history
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_meta_reg <= `SARCV_CLK_IDLE;
      ck_sync_reg <= `SARCV_CLK_IDLE;
      ck_last_reg <= `SARCV_CLK_IDLE;
    end else begin
      ck_meta_reg <= clk_in;
      ck_sync_reg <= ck_meta_reg;
      ck_last_reg <= ck_sync_reg;
    end
  end

  // Clock-in inverted straight through
  assign clk_out = ~clk_in;

  assign ck_fall = ck_last_reg & ~ck_sync_reg;
  // All three low; chip select qualifies the others
  assign start_req = ~cs_n_sync_reg & ~rd_n_sync_reg
    & ~hb_sync_reg;
  assign msb_due = (cnt_reg == `SARCV_FALLS_TO_MSB - 5'h01);
  assign last_bit = (cnt_reg == `SARCV_BITS - 5'h01);
  assign bit_idx = (state_reg == ST_WAIT) ? bit_of(`SARCV_CNT_RST)
    : bit_of(cnt_reg);
  assign decided_word = set_bit(sar_reg, bit_idx, comp_out);

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    busy_n_next = busy_n_reg;
    phase_next = phase_reg;
    case (state_reg)
      ST_SAMPLE: begin
        if (start_req) begin
          state_next = ST_WAIT;
          cnt_next = `SARCV_CNT_RST;
          busy_n_next = 1'b0;
          phase_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (ck_fall) begin
          if (msb_due) begin
            state_next = ST_CONV;
            cnt_next = `SARCV_FIRST_BIT;
          end else begin
            cnt_next = count_up(cnt_reg);
          end
        end
      end
      ST_CONV: begin
        if (ck_fall) begin
          if (last_bit) begin
            state_next = ST_SAMPLE;
            busy_n_next = 1'b1;
            phase_next = 1'b0;
          end else begin
            cnt_next = count_up(cnt_reg);
          end
        end
      end
      default: begin
        state_next = ST_SAMPLE;
        cnt_next = `SARCV_CNT_RST;
        busy_n_next = 1'b1;
        phase_next = 1'b0;
      end
    endcase
  end

  // Data path next values
  always @* begin
    sar_next = sar_reg;
    result_next = result_reg;
    case (state_reg)
      ST_SAMPLE: begin
        if (start_req) begin
          sar_next = `SARCV_SAR_RST;
        end
      end
      ST_WAIT: begin
        if (ck_fall && msb_due) begin
          sar_next = decided_word;
        end
      end
      ST_CONV: begin
        if (ck_fall) begin
          sar_next = decided_word;
          if (last_bit) begin
            result_next = decided_word;
          end
        end
      end
      default: begin
        sar_next = sar_reg;
        result_next = result_reg;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_SAMPLE;
      cnt_reg <= `SARCV_CNT_RST;
      busy_n_reg <= `SARCV_BUSY_N_RST;
      phase_reg <= `SARCV_PHASE_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_n_reg <= busy_n_next;
      phase_reg <= phase_next;
    end
  end

  // Approximation register and output latch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sar_reg <= `SARCV_SAR_RST;
      result_reg <= `SARCV_RES_RST;
    end else begin
      sar_reg <= sar_next;
      result_reg <= result_next;
    end
  end

  // Ports show the registered values
  always @* begin
    busy_n = busy_n_reg;
    compare_phase = phase_reg;
    approximation_register = sar_reg;
  end

  // Pins read the latch, so a starting read sees the old result
  sarcv_bus_mux u_mux (
    .clk(clk),
    .rst(rst),
    .cs_n_s(cs_n_sync_reg),
    .rd_n_s(rd_n_sync_reg),
    .high_byte_select_s(hb_sync_reg),
    .result_bits(result_reg),
    .upper_data_pins(upper_data_pins),
    .shared_low_data_pins(shared_low_data_pins),
    .data_oe(data_oe)
  );
endmodule

// file: sarcv_defines.vh
// Constants for the converter control block
`ifndef SARCV_DEFINES_VH
`define SARCV_DEFINES_VH
`define SARCV_RES_W 12
`define SARCV_MSB 11
`define SARCV_CNT_W 5
`define SARCV_FALLS_TO_MSB 5'h02
`define SARCV_BITS 5'h0c
`define SARCV_RES_RST 12'h000
`define SARCV_SAR_RST 12'h000
`define SARCV_CNT_RST 5'h00
`define SARCV_FIRST_BIT 5'h01
`define SARCV_TOP_BIT 4'hb
`define SARCV_PIN_IDLE 1'b1
`define SARCV_CLK_IDLE 1'b0
`define SARCV_BUSY_N_RST 1'b1
`define SARCV_PHASE_RST 1'b0
`endif

// file: sarcv_bus_mux.v
// Data pin multiplexer and three-state enable for the result latch
`timescale 1ns/10ps
`include "sarcv_defines.vh"
module sarcv_bus_mux (
  input wire clk,
  input wire rst,
  input wire cs_n_s,
  input wire rd_n_s,
  input wire high_byte_select_s,
  input wire [11:0] result_bits,
  output reg [7:0] upper_data_pins,
  output reg [3:0] shared_low_data_pins,
  output wire data_oe
);
  // Drivers on only while both strobes are low
  assign data_oe = ~cs_n_s & ~rd_n_s;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_data_pins <= 8'h00;
      shared_low_data_pins <= 4'h0;
    end else if (high_byte_select_s) begin
      upper_data_pins <= {result_bits[11:8], 4'h0};
      shared_low_data_pins <= result_bits[11:8];
    end else begin
      upper_data_pins <= result_bits[11:4];
      shared_low_data_pins <= result_bits[3:0];
    end
  end
endmodule

// file: sarcv_chk.sv
// Port assertions for the converter control block
`timescale 1ns/10ps
module sarcv_chk (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire rd_n,
  input wire high_byte_select,
  input wire clk_in,
  input wire clk_out,
  input wire busy_n,
  input wire compare_phase,
  input wire [11:0] approximation_register,
  input wire data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start; $fell(busy_n); endsequence
  a_clk_inv: assert property (clk_out == !clk_in)
    else $error("clock out not inverted");
  a_oe_off: assert property (cs_n[*3] |-> !data_oe)
    else $error("drivers on while deselected");
  a_oe_on: assert property ((!cs_n && !rd_n)[*3] |-> data_oe)
    else $error("drivers off during read");
  a_hb_block: assert property (high_byte_select[*4] ##0 busy_n |=> busy_n)
    else $error("start taken with byte select high");
  a_cs_block: assert property (cs_n[*4] ##0 busy_n |=> busy_n)
    else $error("start taken while deselected");
  a_start_clr: assert property (s_start |-> approximation_register == 0)
    else $error("register not cleared at start");
  a_phase_busy: assert property (busy_n != compare_phase)
    else $error("phase and busy disagree");
  a_conv_len: assert property (s_start |-> ##[100:140] $rose(busy_n))
    else $error("conversion length wrong");
endmodule
bind sarcv_ctrl sarcv_chk chk_u (.clk, .rst, .cs_n, .rd_n, .high_byte_select,
  .clk_in, .clk_out, .busy_n, .compare_phase, .approximation_register,
  .data_oe);

// file: sarcv_host_model.sv
// Converter clock source and comparator stand-in
`timescale 1ns/10ps
module sarcv_host_model (
  input wire logic comp_level,
  input wire logic busy_n,
  output logic clk_in,
  output wire logic comp_out
);
  logic flip_q = 1'b0;
  initial clk_in = 1'b0;
  always #100 clk_in = ~clk_in;
  // Answer alternates per decision while converting
  always @(posedge clk_in) flip_q <= busy_n ? 1'b0 : ~flip_q;
  assign comp_out = comp_level ^ flip_q;
endmodule

// file: sar_adc_conversion_bus_port_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sar_adc_conversion_bus_port_test;
  logic clk = 0, rst = 1, cs_n = 1, rd_n = 1, hb = 0, comp = 0;
  wire clk_in, comp_out, clk_out, busy_n, cph, data_oe;
  wire [11:0] sar;
  wire [7:0] up;
  wire [3:0] lo;
  wire [11:0] bus = data_oe ? {up, lo} : 12'hzzz;
  int err_total = 0, num_checks = 0;
  always #10 clk = ~clk;
  sarcv_host_model host_u (.comp_level(comp), .busy_n(busy_n),
    .clk_in(clk_in), .comp_out(comp_out));
  sarcv_ctrl dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .high_byte_select(hb), .clk_in(clk_in), .comp_out(comp_out),
    .clk_out(clk_out), .busy_n(busy_n), .compare_phase(cph),
    .approximation_register(sar), .upper_data_pins(up),
    .shared_low_data_pins(lo), .data_oe(data_oe));
  task give_verdict;
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_busy(input logic lvl);
    for (int n = 0; n < 400 && busy_n !== lvl; n++) @(negedge clk);
    if (busy_n !== lvl) begin
      err_total++;
      give_verdict;
    end
  endtask
  task sync_start;
    for (int n = 0; n < 10 && $time % 100 != 60; n++) @(negedge clk);
    if ($time % 100 != 60) begin
      err_total++;
      give_verdict;
    end
  endtask
  task t_cs_block;
    rd_n = 0;
    repeat (10) @(negedge clk);
    chk(busy_n, 1);
    chk(bus, 12'hzzz);
    rd_n = 1;
  endtask
  task t_convert(input logic c, input logic [11:0] prev,
    input logic [11:0] res);
    comp = c;
    sync_start;
    chk(clk_out, !clk_in);
    cs_n = 0;
    rd_n = 0;
    repeat (4) @(negedge clk);
    chk(bus, prev);
    wait_busy(0);
    chk(sar, 12'h000);
    chk(cph, 1);
    cs_n = 1;
    rd_n = 1;
    wait_busy(1);
    chk(sar, res);
    repeat (3) @(negedge clk);
    cs_n = 0;
    rd_n = 0;
    hb = 1;
    repeat (4) @(negedge clk);
    chk(bus, {res[11:8], 4'h0, res[11:8]});
    chk(busy_n, 1);
    cs_n = 1;
    rd_n = 1;
    hb = 0;
    repeat (50) @(negedge clk);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_cs_block;
    t_convert(1, 12'h000, 12'h555);
    t_convert(0, 12'h555, 12'haaa);
    give_verdict;
  end
endmodule
